//--- include/dci_defines.svh
`ifndef DCI_DEFINES_SVH
`define DCI_DEFINES_SVH

// ----------------------------------------
// Widths and figures
// ----------------------------------------
`define DCI_CNT_W 32
`define DCI_FRAC_W 16
`define DCI_MIN_TICKS 32'h00004E20
`define DCI_MAX_WHOLE 32'h00002710

`endif

//--- include/dci_pkg.sv
package dci_pkg;

  // ----------------------------------------
  // Run sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    DCI_IDLE = 4'h1,
    DCI_ARM = 4'h2,
    DCI_RUN = 4'h4,
    DCI_TAIL = 4'h8
  } dci_state_t;

endpackage

//--- rtl/dci_divider.sv
`timescale 1ns/1ps
`include "dci_defines.svh"

// ----------------------------------------
// Restoring divider, fixed point quotient
// ----------------------------------------
module dci_divider #(
  parameter int CW = `DCI_CNT_W,
  parameter int FW = `DCI_FRAC_W
) (
  // Clock
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Operands
  input wire logic start,
  input wire logic [2*CW-1:0] dividend,
  input wire logic [CW-1:0] divisor,
  // Result
  output logic busy,
  output logic done,
  output logic [CW+FW-1:0] quotient
);

  localparam int QW = CW + FW;
  localparam int NW = 2 * CW + FW;

  logic [NW-1:0] num_r;
  logic [CW:0] rem_r;
  logic [7:0] cnt_r;
  logic [CW:0] trial;

  always_comb begin
    trial = {rem_r[CW-1:0], num_r[NW-1]} - {1'b0, divisor};
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      num_r <= '0;
      rem_r <= '0;
      cnt_r <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= '0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && !busy) begin
        num_r <= {dividend, {FW{1'b0}}};
        rem_r <= '0;
        cnt_r <= 8'(NW);
        busy <= 1'b1;
      end else if (busy) begin
        num_r <= {num_r[NW-2:0], ~trial[CW]};
        rem_r <= trial[CW] ? {rem_r[CW-1:0], num_r[NW-1]} : trial;
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
          quotient <= QW'({num_r[NW-2:0], ~trial[CW]});
        end
      end
    end
  end

endmodule // dci_divider

//--- rtl/dci_interpolator.sv
`timescale 1ns/1ps
`include "dci_defines.svh"

// What this block does
// RL1: Count whole flowmeter pulses during a proving run.
// RL2: First timer counts reference clocks while whole pulses accumulate.
// RL3: Second timer counts reference clocks between first and last detector.
// RL4: Pulse counter and first timer span first pulse after each detector.
// RL5: Detector switch signals start and stop the counter and both timers; here they gate only the second timer, the counter and first timer follow RL4.
// RL6: Interpolated count is whole count times detector over pulse timer.
// RL7: Reference clock must exceed meter rate times 20,000 over count.
// RL8: Each timer must gather more than 20,000 clocks per prove.
// RL9: Reach 0.02% discrimination with fewer than 10,000 whole pulses.
// RL10: Reported count within 0.01% of generator-derived value.
// RL11: Tester accepts a run only below 0.0001 relative difference.
// RL12: Expose both timers, whole count and interpolated count.
// RL13: Hold results stable and flag valid after last detector and pulse.
module dci_interpolator #(
  parameter int CW = `DCI_CNT_W,
  parameter int FW = `DCI_FRAC_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Field inputs
  input wire logic meter_pulse,
  input wire logic detector_sw,
  // Run control
  input wire logic run_arm,
  // Results
  output logic [CW-1:0] whole_pulse_count_r,
  output logic [CW-1:0] pulse_span_time_r,
  output logic [CW-1:0] detector_span_time_r,
  output logic [CW+FW-1:0] interp_count_r,
  output logic results_valid_r,
  output logic timing_ok_r,
  output logic run_active_r
);

  // ----------------------------------------
  // Input synchronisers and edges
  // ----------------------------------------
  logic [1:0] mp_sync_r;
  logic [1:0] det_sync_r;
  logic mp_last_r;
  logic det_last_r;
  logic mp_edge;
  logic det_edge;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mp_sync_r <= 2'h0;
      det_sync_r <= 2'h0;
      mp_last_r <= 1'b0;
      det_last_r <= 1'b0;
    end else if (clk_en) begin
      mp_sync_r <= {mp_sync_r[0], meter_pulse};
      det_sync_r <= {det_sync_r[0], detector_sw};
      mp_last_r <= mp_sync_r[1];
      det_last_r <= det_sync_r[1];
    end
  end

  assign mp_edge = mp_sync_r[1] && !mp_last_r;
  assign det_edge = det_sync_r[1] && !det_last_r;

  // ----------------------------------------
  // Run sequencer
  // ----------------------------------------
  dci_pkg::dci_state_t state_r;
  dci_pkg::dci_state_t state_nxt;
  logic det_run;
  logic mp_run;
  logic run_done;
  logic mp_last_edge;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dci_pkg::DCI_IDLE: begin
        if (run_arm) begin
          state_nxt = dci_pkg::DCI_ARM;
        end
      end
      dci_pkg::DCI_ARM: begin
        if (det_edge) begin
          state_nxt = dci_pkg::DCI_RUN; // RL5
        end
      end
      dci_pkg::DCI_RUN: begin
        if (det_edge) begin
          state_nxt = dci_pkg::DCI_TAIL; // RL5
        end
      end
      dci_pkg::DCI_TAIL: begin
        if (mp_last_edge) begin
          state_nxt = dci_pkg::DCI_IDLE;
        end
      end
      default: state_nxt = dci_pkg::DCI_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= dci_pkg::DCI_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Detector span is open in RUN
  assign det_run = (state_r == dci_pkg::DCI_RUN);

  // ----------------------------------------
  // Pulse gate: first pulse after each detector
  // ----------------------------------------
  logic mp_gate_r;

  assign mp_last_edge = (state_r == dci_pkg::DCI_TAIL) && mp_edge && mp_gate_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mp_gate_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == dci_pkg::DCI_ARM) begin
        mp_gate_r <= 1'b0;
      end else if (mp_edge && !mp_gate_r && (det_run || state_r == dci_pkg::DCI_TAIL)) begin
        mp_gate_r <= 1'b1; // RL4
      end else if (mp_last_edge) begin
        mp_gate_r <= 1'b0; // RL4
      end
    end
  end

  assign mp_run = mp_gate_r;
  assign run_done = mp_last_edge && !det_run;

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic [CW-1:0] n_cnt_r;
  logic [CW-1:0] t1_cnt_r;
  logic [CW-1:0] t2_cnt_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || (clk_en && state_r == dci_pkg::DCI_ARM)) begin
      n_cnt_r <= '0;
    end else if (clk_en && mp_run && mp_edge) begin
      n_cnt_r <= n_cnt_r + 1'b1; // RL1
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || (clk_en && state_r == dci_pkg::DCI_ARM)) begin
      t1_cnt_r <= '0;
    end else if (clk_en && mp_run) begin
      t1_cnt_r <= t1_cnt_r + 1'b1; // RL2
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || (clk_en && state_r == dci_pkg::DCI_ARM)) begin
      t2_cnt_r <= '0;
    end else if (clk_en && det_run) begin
      t2_cnt_r <= t2_cnt_r + 1'b1; // RL3
    end
  end

  // ----------------------------------------
  // Interpolation N * T2 / T1
  // ----------------------------------------
  logic div_busy;
  logic div_done;
  logic [CW+FW-1:0] div_q;
  logic div_start_r;
  logic run_done_r;
  logic [2*CW-1:0] prod_r;

  // Latch a cycle late so the closing pulse and tick are counted
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_start_r <= 1'b0;
      run_done_r <= 1'b0;
      prod_r <= '0;
    end else if (clk_en) begin
      run_done_r <= run_done; // RL4
      div_start_r <= run_done_r;
      if (run_done_r) begin
        prod_r <= (2*CW)'(n_cnt_r) * (2*CW)'(t2_cnt_r); // RL6
      end
    end
  end

  dci_divider #(.CW(CW), .FW(FW)) u_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .start(div_start_r),
    .dividend(prod_r),
    .divisor(pulse_span_time_r),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q)
  );

  // ----------------------------------------
  // Result holding and reporting
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      whole_pulse_count_r <= '0;
      pulse_span_time_r <= '0;
      detector_span_time_r <= '0;
      interp_count_r <= '0;
      results_valid_r <= 1'b0;
      timing_ok_r <= 1'b0;
      run_active_r <= 1'b0;
    end else if (clk_en) begin
      run_active_r <= (state_nxt != dci_pkg::DCI_IDLE);
      if (state_r == dci_pkg::DCI_ARM) begin
        results_valid_r <= 1'b0;
      end
      if (run_done_r) begin
        whole_pulse_count_r <= n_cnt_r; // RL12
        pulse_span_time_r <= t1_cnt_r; // RL12
        detector_span_time_r <= t2_cnt_r; // RL12
        timing_ok_r <= (t1_cnt_r > `DCI_MIN_TICKS) && (t2_cnt_r > `DCI_MIN_TICKS)
          && (n_cnt_r < `DCI_MAX_WHOLE); // RL7 RL8 RL9
      end
      if (div_done) begin
        interp_count_r <= div_q; // RL10
        results_valid_r <= 1'b1; // RL13
      end
    end
  end

endmodule // dci_interpolator

//--- tb/dci_monitor.sv
`timescale 1ns/1ps
`include "dci_defines.svh"

module dci_monitor #(
  parameter int CW = `DCI_CNT_W,
  parameter int FW = `DCI_FRAC_W
) (
  // Control
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic run_arm,
  // Results
  input wire logic [CW-1:0] whole_pulse_count_r,
  input wire logic [CW-1:0] pulse_span_time_r,
  input wire logic [CW-1:0] detector_span_time_r,
  input wire logic [CW+FW-1:0] interp_count_r,
  input wire logic results_valid_r,
  input wire logic timing_ok_r,
  input wire logic run_active_r
);
  // ----------------------------
  // Run checks
  // ----------------------------
  logic fine;
  assign fine = pulse_span_time_r > `DCI_MIN_TICKS && detector_span_time_r > `DCI_MIN_TICKS
    && whole_pulse_count_r < `DCI_MAX_WHOLE;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  rst_clear_a: assert property (disable iff (1'b0) sys_rst && clk_en |=>
    !results_valid_r && !run_active_r && whole_pulse_count_r == '0) else $error("reset kept");
  arm_start_a: assert property (!run_active_r && run_arm && clk_en |=> run_active_r)
    else $error("arm lost");
  idle_hold_a: assert property (!run_active_r && !run_arm |=> !run_active_r)
    else $error("run unarmed");
  result_hold_a: assert property (results_valid_r && !run_active_r && !run_arm
    |=> $stable(interp_count_r) && $stable(whole_pulse_count_r)) else $error("result moved");
  valid_drop_a: assert property ($rose(run_active_r) |-> ##[0:2] !results_valid_r)
    else $error("valid kept");
  ok_true_a: assert property (timing_ok_r |-> fine) else $error("ok wrong");
  ok_false_a: assert property (results_valid_r && fine |-> timing_ok_r)
    else $error("ok missing");
  interp_ratio_a: assert property (results_valid_r && pulse_span_time_r != '0 |->
    96'(interp_count_r) * pulse_span_time_r <= 96'(whole_pulse_count_r) * detector_span_time_r << FW
    && (96'(whole_pulse_count_r) * detector_span_time_r << FW)
    < (96'(interp_count_r) + 1) * pulse_span_time_r) else $error("ratio wrong");
  cover property ($rose(results_valid_r));
  cover property ($rose(timing_ok_r));
  cover property (run_active_r && run_arm);
endmodule // dci_monitor

bind dci_interpolator dci_monitor #(.CW(CW), .FW(FW)) u_mon (.ref_clk, .sys_rst, .clk_en,
  .run_arm, .whole_pulse_count_r, .pulse_span_time_r, .detector_span_time_r,
  .interp_count_r, .results_valid_r, .timing_ok_r, .run_active_r);

//--- tb/dci_field_model.sv
`timescale 1ns/1ps

module dci_field_model (
  // Control
  input wire logic ref_clk,
  input wire logic [31:0] period,
  input wire logic det_req,
  // Field lines
  output logic meter_pulse = 1'b0,
  output logic detector_sw = 1'b0
);
  // ----------------------------
  // Meter train and switch
  // ----------------------------
  int cnt = 0;
  always_ff @(posedge ref_clk) begin
    cnt <= (cnt >= period - 1) ? 0 : cnt + 1;
    meter_pulse <= (cnt < period / 2);
    detector_sw <= det_req;
  end
endmodule // dci_field_model

//--- tb/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  // ----------------------------
  // Bench signals
  // ----------------------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic run_arm = 1'b0;
  logic det_req = 1'b0;
  int period = 40;
  logic meter_pulse, detector_sw, results_valid_r, timing_ok_r, run_active_r;
  logic [31:0] whole_pulse_count_r, pulse_span_time_r, detector_span_time_r;
  logic [47:0] interp_count_r;
  int bad_count = 0;
  int n_tests = 0;
  always #10 ref_clk = ~ref_clk;
  dci_field_model FM (.ref_clk, .period, .det_req, .meter_pulse, .detector_sw);
  dci_interpolator DUT (.ref_clk, .sys_rst, .clk_en, .meter_pulse, .detector_sw, .run_arm,
    .whole_pulse_count_r, .pulse_span_time_r, .detector_span_time_r, .interp_count_r,
    .results_valid_r, .timing_ok_r, .run_active_r);

  task chk(input string nm, input logic [63:0] e, input logic [63:0] g, input bit tol);
    n_tests++;
    if (!(g === e || (tol && (g === e + 1 || g === e - 1)))) begin
      bad_count++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic run_case(input int p, input int d, input bit mid, input bit ok_e);
    int k;
    real q;
    period <= p;
    k = (d + 4) / p + 1;
    repeat (4) @(posedge ref_clk);
    run_arm <= 1'b1;
    @(posedge ref_clk) run_arm <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("results_valid_r", 0, results_valid_r, 0);
    @(posedge meter_pulse);
    repeat (3) @(posedge ref_clk);
    det_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    det_req <= 1'b0;
    repeat (d - 5) @(posedge ref_clk);
    run_arm <= mid;
    @(posedge ref_clk) run_arm <= 1'b0;
    det_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    det_req <= 1'b0;
    for (int i = 0; i < p + 300 && results_valid_r !== 1'b1; i++) @(posedge ref_clk);
    q = real'(interp_count_r) * p / 65536.0 / d;
    chk("results_valid_r", 1, results_valid_r, 0);
    chk("whole_pulse_count_r", 64'(k - 1), whole_pulse_count_r, 0);
    chk("pulse_span_time_r", 64'((k - 1) * p), pulse_span_time_r, 1);
    chk("detector_span_time_r", 64'(d), detector_span_time_r, 1);
    chk("timing_ok_r", 64'(ok_e), timing_ok_r, 0);
    chk("interp_count_r", 1, 64'(q > 0.9999 && q < 1.0001), 0);
  endtask

  task automatic reset_mid;
    clk_en <= 1'b0;
    run_arm <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("run_active_r", 0, run_active_r, 0);
    chk("results_valid_r", 1, results_valid_r, 0);
    clk_en <= 1'b1;
    @(posedge ref_clk) run_arm <= 1'b0;
    det_req <= 1'b1;
    repeat (4) @(posedge ref_clk);
    det_req <= 1'b0;
    repeat (50) @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("run_active_r", 0, run_active_r, 0);
    chk("whole_pulse_count_r", 0, whole_pulse_count_r, 0);
  endtask

  task give_verdict;
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    run_case(40, 1010, 1'b0, 1'b0);
    run_case(300, 25100, 1'b1, 1'b1);
    reset_mid();
    give_verdict();
  end

  initial begin
    #1000000;
    bad_count++;
    give_verdict();
  end
endmodule // tb_top
